//--- hdl/svt_pkg.sv
// Shared constants and carrier types for the calibration and test register bank.
package svt_pkg;

  localparam int NREG = 15;
  localparam logic [7:0] ADDR_START = 8'h00;

  // Register offsets.
  localparam logic [7:0] A_CONV_CTRL  = 8'h32;
  localparam logic [7:0] A_CLK_DIV    = 8'h35;
  localparam logic [7:0] A_PUMP_OFS   = 8'h36;
  localparam logic [7:0] A_BAND       = 8'h37;
  localparam logic [7:0] A_CORE_BIAS  = 8'h38;
  localparam logic [7:0] A_MUX_TUNE   = 8'h39;
  localparam logic [7:0] A_CAL_OFS    = 8'h3A;
  localparam logic [7:0] A_MOD_RST    = 8'h3D;
  localparam logic [7:0] A_PUMP_TEST  = 8'h3E;
  localparam logic [7:0] A_DIV1_LO    = 8'h3F;
  localparam logic [7:0] A_BUF_DIV1HI = 8'h40;
  localparam logic [7:0] A_DIV2_LO    = 8'h41;
  localparam logic [7:0] A_DIV2_HI    = 8'h42;
  localparam logic [7:0] A_OSC_MUX    = 8'h47;
  localparam logic [7:0] A_CLK_CTRL   = 8'h73;

  // Table of offsets, reset values and writable bits, one entry per register.
  localparam logic [7:0] REG_ADDR [NREG] = '{
    A_CONV_CTRL, A_CLK_DIV, A_PUMP_OFS, A_BAND, A_CORE_BIAS, A_MUX_TUNE, A_CAL_OFS,
    A_MOD_RST, A_PUMP_TEST, A_DIV1_LO, A_BUF_DIV1HI, A_DIV2_LO, A_DIV2_HI,
    A_OSC_MUX, A_CLK_CTRL};
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h04, 8'h4C, 8'h30, 8'h00, 8'h00, 8'h07, 8'h55,
    8'h00, 8'h0C, 8'h80, 8'h50, 8'h28, 8'h00, 8'hC0, 8'h00};
  localparam logic [7:0] REG_WMASK [NREG] = '{
    8'h0C, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF,
    8'h40, 8'h0C, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hE0, 8'h04};

  // Table indices of the registers that steer logic.
  localparam int I_CONV_CTRL = 0;
  localparam int I_CLK_DIV   = 1;
  localparam int I_BAND      = 3;
  localparam int I_CORE_BIAS = 4;
  localparam int I_MUX_TUNE  = 5;
  localparam int I_CAL_OFS   = 6;
  localparam int I_PUMP_TEST = 8;
  localparam int I_CLK_CTRL  = 14;

  // Field positions.
  localparam int B_CONV_EN   = 3;
  localparam int B_ADC_EN    = 2;
  localparam int B_CLK_DIS   = 2;
  localparam int P_CORE_LSB  = 4;
  localparam int P_PROBE_LSB = 4;
  localparam int P_PUMP_LSB  = 2;

  // Tuning target code limits.
  localparam logic [3:0] TUNE_LOW_TOP = 4'h3;
  localparam logic [3:0] TUNE_HI_BOT  = 4'hC;

  // Pump test codes.
  localparam logic [1:0] PUMP_TRI  = 2'h0;
  localparam logic [1:0] PUMP_NORM = 2'h3;

  typedef enum logic [2:0] {
    PR_BUSY, PR_NBAND, PR_RBAND, PR_RSVD, PR_TMO_CLK, PR_BIAS_MIN, PR_CONV_BUSY, PR_LOW
  } svt_probe_t;

  // Calibration machine status signals seen by the probe multiplexer.
  typedef struct packed {
    logic busy;
    logic n_band;
    logic r_band;
    logic timeout_clk;
    logic bias_min;
    logic conv_busy;
  } svt_status_t;

  // Test override bundle handed to the oscillator.
  typedef struct packed {
    logic       en;
    logic [7:0] band;
    logic [3:0] core;
    logic [3:0] bias;
    logic [3:0] tune_step;
  } svt_override_t;

endpackage

//--- hdl/svt_conv_clk_div.sv
// Converter clock divider counting phase-detector ticks.
`timescale 1ns/1ns
module svt_conv_clk_div
  import svt_pkg::*;
#(
  parameter int DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          run_i,
  input  wire logic          tick_i,
  input  wire logic [DW-1:0] div_i,
  output logic               conv_clk_o
);

  logic [DW:0] cnt;
  logic [DW:0] half_m1;

  // Each half period is 2*div+1 ticks, so a full period is 4*div+2.
  assign half_m1 = {div_i, 1'b0};

  // The compare is >= so that a smaller divider never strands the count.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt        <= '0;
      conv_clk_o <= 1'b0;
    end else if (!run_i) begin
      cnt        <= '0;
      conv_clk_o <= 1'b0;
    end else if (tick_i) begin
      if (cnt >= half_m1) begin
        cnt        <= '0;
        conv_clk_o <= ~conv_clk_o;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule

//--- hdl/svt_test_decode.sv
// Test override decode and calibration probe multiplexer.
`timescale 1ns/1ns
module svt_test_decode
  import svt_pkg::*;
(
  input  wire logic          test_mode_i,
  input  wire logic [7:0]    band_i,
  input  wire logic [3:0]    core_i,
  input  wire logic [3:0]    bias_i,
  input  wire logic [3:0]    tune_i,
  input  wire logic [2:0]    probe_sel_i,
  input  wire svt_status_t   status_i,
  output svt_override_t      ovr_o,
  output logic               probe_o
);

  logic [3:0] core_onehot;
  logic [3:0] step;

  // Only single-hot patterns enable a core; anything else keeps all cores off.
  always_comb begin
    case (core_i)
      4'h1, 4'h2, 4'h4, 4'h8: core_onehot = core_i;
      default:                core_onehot = 4'h0;
    endcase
  end

  // Low codes clamp to the floor, high codes to the ceiling, step 0 is 1.18 V.
  always_comb begin
    if (tune_i <= TUNE_LOW_TOP) begin
      step = 4'h0;
    end else if (tune_i >= TUNE_HI_BOT) begin
      step = TUNE_HI_BOT - TUNE_LOW_TOP;
    end else begin
      step = tune_i - TUNE_LOW_TOP;
    end
  end

  // Overrides are zero outside test mode.
  always_comb begin
    ovr_o = '0;
    if (test_mode_i) begin
      ovr_o.en        = 1'b1;
      ovr_o.band      = band_i;
      ovr_o.core      = core_onehot;
      ovr_o.bias      = bias_i;
      ovr_o.tune_step = step;
    end
  end

  // Probe selection.
  always_comb begin
    case (svt_probe_t'(probe_sel_i))
      PR_BUSY:      probe_o = status_i.busy;
      PR_NBAND:     probe_o = status_i.n_band;
      PR_RBAND:     probe_o = status_i.r_band;
      PR_TMO_CLK:   probe_o = status_i.timeout_clk;
      PR_BIAS_MIN:  probe_o = status_i.bias_min;
      PR_CONV_BUSY: probe_o = status_i.conv_busy;
      default:      probe_o = 1'b0;
    endcase
  end

endmodule

//--- hdl/svt_regs.sv
// Calibration and test register bank for the synthesizer oscillator.
//
// Summary of operation
// - Converter clock is PFD over (4*div+2).
// - Test mode applies forced band select.
// - One-hot forced core field picks core.
// - Forced bias field, zero is maximum bias.
// - Three-bit selector drives calibration probe output.
// - Forced tune target clamps low and high.
// - Offset trim corrects converter results.
// - Pump test field: zero tristate, three normal.
// - Write to address zero starts conversion.
// - Converter enable overrides clock disable bit.
//
// The block has no knowledge of the phase-detector rate; it only
// counts the ticks it is given, so the 100 kHz target is the
// programmer's business.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
module svt_regs
  import svt_pkg::*;
#(
  parameter int DW = 8
) (
  input  wire logic          CLK_I,
  input  wire logic          NRST_I,
  input  wire logic [7:0]    ADDR_I,
  input  wire logic [7:0]    WDATA_I,
  input  wire logic          WR_I,
  input  wire logic          RD_I,
  output logic [7:0]         RDATA_O,
  input  wire logic          PFD_TICK_I,
  input  wire logic          TEST_MODE_I,
  input  wire svt_status_t   STATUS_I,
  input  wire logic [7:0]    CONV_RESULT_I,
  input  wire logic          CONV_VALID_I,
  output logic               CONV_CLK_O,
  output logic               CONV_START_O,
  output logic [7:0]         CAL_RESULT_O,
  output logic               CAL_VALID_O,
  output svt_override_t      OVERRIDE_O,
  output logic               PROBE_O,
  output logic               PUMP_TRISTATE_O,
  output logic               PUMP_NORMAL_O
);

  // Reset synchroniser.
  logic rst_meta;
  logic rst_n;

  // Register storage.
  logic [7:0] regs [NREG];

  // Decoded fields.
  logic       conv_en;
  logic       adc_en;
  logic       clk_dis;
  logic       clk_run;
  logic [1:0] pump_code;
  logic [2:0] probe_sel;

  // Read path.
  logic [7:0] next_rdata;

  // Converter result path.
  logic [8:0] diff;
  logic [7:0] next_cal;

  // Registered decode outputs.
  svt_override_t ovr_c;
  logic          probe_c;

  // Release of the asynchronous reset passes two flops so that
  // every register leaves reset on the same edge.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // One storage loop for every register of the table.
  // Bits outside the write mask hold their reset value, which is
  // zero for every read-only reserved bit, so they read as zero.
  for (genvar gi = 0; gi < NREG; gi++) begin : g_reg
    always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
        regs[gi] <= REG_RST[gi];
      end else if (WR_I && (ADDR_I == REG_ADDR[gi])) begin
        regs[gi] <= (WDATA_I & REG_WMASK[gi]) | (regs[gi] & ~REG_WMASK[gi]);
      end
    end
  end

  // Address decode for reads.
  // An unmapped address, and the start address, read as zero.
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (ADDR_I == REG_ADDR[i]) begin
        next_rdata = regs[i];
      end
    end
  end

  // Read data stand only in the cycle after the read strobe.
  // Holding them longer would hide a missed strobe from the master.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      RDATA_O <= next_rdata;
    end else begin
      RDATA_O <= 8'h00;
    end
  end

  // Converter control fields.
  assign conv_en = regs[I_CONV_CTRL][B_CONV_EN];
  assign adc_en  = regs[I_CONV_CTRL][B_ADC_EN];
  assign clk_dis = regs[I_CLK_CTRL][B_CLK_DIS];

  // An enabled converter always gets its clock, whatever the
  // disable bit says.
  assign clk_run = adc_en | ~clk_dis;

  // Converter clock from the phase-detector tick.
  svt_conv_clk_div #(
    .DW (DW)
  ) u_div (
    .clk_i      (CLK_I),
    .rst_n_i    (rst_n),
    .run_i      (clk_run),
    .tick_i     (PFD_TICK_I),
    .div_i      (regs[I_CLK_DIV]),
    .conv_clk_o (CONV_CLK_O)
  );

  // A write to address zero starts one conversion when both the
  // conversion and the converter are enabled; the pulse lasts one cycle.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CONV_START_O <= 1'b0;
    end else begin
      CONV_START_O <= WR_I && (ADDR_I == ADDR_START) && conv_en && adc_en;
    end
  end

  // Offset correction: the trim is subtracted from each raw result.
  // The difference saturates at zero rather than wrapping, so a trim
  // larger than the reading gives the floor and not a huge value.
  assign diff = {1'b0, CONV_RESULT_I} - {1'b0, regs[I_CAL_OFS]};

  always_comb begin
    if (diff[8]) begin
      next_cal = 8'h00;
    end else begin
      next_cal = diff[7:0];
    end
  end

  // Corrected results leave one cycle after their valid.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CAL_RESULT_O <= 8'h00;
      CAL_VALID_O  <= 1'b0;
    end else begin
      CAL_VALID_O <= CONV_VALID_I;
      if (CONV_VALID_I) begin
        CAL_RESULT_O <= next_cal;
      end
    end
  end

  // Test override and probe decode.
  assign probe_sel = regs[I_MUX_TUNE][P_PROBE_LSB +: 3];

  svt_test_decode u_dec (
    .test_mode_i (TEST_MODE_I),
    .band_i      (regs[I_BAND]),
    .core_i      (regs[I_CORE_BIAS][P_CORE_LSB +: 4]),
    .bias_i      (regs[I_CORE_BIAS][3:0]),
    .tune_i      (regs[I_MUX_TUNE][3:0]),
    .probe_sel_i (probe_sel),
    .status_i    (STATUS_I),
    .ovr_o       (ovr_c),
    .probe_o     (probe_c)
  );

  // Overrides are registered so the analog side sees no decode glitch.
  // Band, core, bias and tune follow the test mode with one cycle lag.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      OVERRIDE_O <= '0;
    end else begin
      OVERRIDE_O <= ovr_c;
    end
  end

  // The probe is registered as a data output; it lags its source by one cycle.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PROBE_O <= 1'b0;
    end else begin
      PROBE_O <= probe_c;
    end
  end

  // Pump test decode; codes one and two assert neither output.
  assign pump_code = regs[I_PUMP_TEST][P_PUMP_LSB +: 2];

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PUMP_TRISTATE_O <= 1'b0;
      PUMP_NORMAL_O   <= 1'b0;
    end else begin
      PUMP_TRISTATE_O <= (pump_code == PUMP_TRI);
      PUMP_NORMAL_O   <= (pump_code == PUMP_NORM);
    end
  end

endmodule

//--- testbench/svt_regs_asserts.sv
// Concurrent checks on the ports of the calibration and test register bank.
`timescale 1ns/1ns
module svt_regs_asserts
  import svt_pkg::*;
(
  input wire logic          CLK_I,
  input wire logic          NRST_I,
  input wire logic [7:0]    ADDR_I,
  input wire logic          WR_I,
  input wire logic          RD_I,
  input wire logic [7:0]    RDATA_O,
  input wire logic          PFD_TICK_I,
  input wire logic          TEST_MODE_I,
  input wire logic [7:0]    CONV_RESULT_I,
  input wire logic          CONV_VALID_I,
  input wire logic          CONV_CLK_O,
  input wire logic          CONV_START_O,
  input wire logic [7:0]    CAL_RESULT_O,
  input wire logic          CAL_VALID_O,
  input wire svt_override_t OVERRIDE_O
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);

  // The start location is write-only and must read back as zero.
  sequence s_rd_start;
    RD_I && ADDR_I == 8'h00;
  endsequence
  property p_rd_start;
    s_rd_start |=> RDATA_O == 8'h00;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("start location read nonzero");

  // A start pulse needs a write to the start location just before it.
  property p_start;
    !(WR_I && ADDR_I == 8'h00) |=> !CONV_START_O;
  endproperty
  a_start: assert property (p_start) else $error("start pulse without write");

  // A corrected result follows each raw one and never exceeds it.
  sequence s_conv;
    CONV_VALID_I;
  endsequence
  property p_cal;
    s_conv |=> CAL_VALID_O && CAL_RESULT_O <= $past(CONV_RESULT_I);
  endproperty
  a_cal: assert property (p_cal) else $error("corrected result missing or too big");

  // Without a raw result the corrected one is neither flagged nor changed.
  property p_cal_hold;
    !CONV_VALID_I |=> !CAL_VALID_O && $stable(CAL_RESULT_O);
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("corrected result moved");

  // Overrides are quiet one cycle after test mode was off.
  property p_ovr_off;
    !$past(TEST_MODE_I) |-> OVERRIDE_O == '0;
  endproperty
  a_ovr_off: assert property (p_ovr_off) else $error("override outside test mode");

  // At most one oscillator core is ever enabled.
  property p_core;
    $onehot0(OVERRIDE_O.core);
  endproperty
  a_core: assert property (p_core) else $error("more than one core enabled");

  // The tuning target is clamped to its top step.
  property p_tune;
    OVERRIDE_O.tune_step <= 4'h9;
  endproperty
  a_tune: assert property (p_tune) else $error("tune step above clamp");

  // The converter clock only rises on a phase-detector tick.
  property p_clk;
    $rose(CONV_CLK_O) |-> $past(PFD_TICK_I);
  endproperty
  a_clk: assert property (p_clk) else $error("converter clock rose without tick");
endmodule

bind svt_regs svt_regs_asserts u_chk (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .PFD_TICK_I(PFD_TICK_I), .TEST_MODE_I(TEST_MODE_I),
  .CONV_RESULT_I(CONV_RESULT_I), .CONV_VALID_I(CONV_VALID_I), .CONV_CLK_O(CONV_CLK_O),
  .CONV_START_O(CONV_START_O), .CAL_RESULT_O(CAL_RESULT_O), .CAL_VALID_O(CAL_VALID_O),
  .OVERRIDE_O(OVERRIDE_O));

//--- testbench/svt_regs_tb.sv
// Self-checking bench for the calibration and test register bank.
`timescale 1ns/1ns
module svt_regs_tb
  import svt_pkg::*;
;
  logic          CLK_I, NRST_I, WR_I, RD_I, PFD_TICK_I, TEST_MODE_I, CONV_VALID_I;
  logic [7:0]    ADDR_I, WDATA_I, CONV_RESULT_I, RDATA_O, CAL_RESULT_O, d, t, r;
  logic          CONV_CLK_O, CONV_START_O, CAL_VALID_O, PROBE_O, PUMP_TRISTATE_O, PUMP_NORMAL_O;
  svt_status_t   STATUS_I;
  svt_override_t OVERRIDE_O;
  int            miscompares, cmp_count, seed, n;

  svt_regs dut (.CLK_I(CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .PFD_TICK_I(PFD_TICK_I),
    .TEST_MODE_I(TEST_MODE_I), .STATUS_I(STATUS_I), .CONV_RESULT_I(CONV_RESULT_I),
    .CONV_VALID_I(CONV_VALID_I), .CONV_CLK_O(CONV_CLK_O), .CONV_START_O(CONV_START_O),
    .CAL_RESULT_O(CAL_RESULT_O), .CAL_VALID_O(CAL_VALID_O), .OVERRIDE_O(OVERRIDE_O),
    .PROBE_O(PROBE_O), .PUMP_TRISTATE_O(PUMP_TRISTATE_O), .PUMP_NORMAL_O(PUMP_NORMAL_O));

  // Free-running 10 MHz clock.
  initial begin
    CLK_I = 1'b0;
    forever #50 CLK_I = ~CLK_I;
  end

  // Four-state compare, so an unknown never passes.
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Let an edge land, then look at settled outputs.
  task automatic step;
    @(posedge CLK_I);
    #1;
  endtask

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK_I);
    ADDR_I <= a;
    WDATA_I <= v;
    WR_I <= 1'b1;
    @(posedge CLK_I);
    WR_I <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    #1;
    chk(RDATA_O, exp);
  endtask

  // Bounded wait for a converter clock level; the slowest divider holds a level for 511 ticks.
  task automatic wait_lvl(input logic v);
    n = 0;
    while (CONV_CLK_O !== v && n < 600) begin
      step;
      n++;
    end
  endtask

  function automatic logic [3:0] f_tune(input logic [3:0] c);
    return (c <= 4'h3) ? 4'h0 : (c >= 4'hC) ? 4'h9 : c - 4'h3;
  endfunction

  function automatic logic [3:0] f_core(input logic [3:0] c);
    return (c inside {4'h1, 4'h2, 4'h4, 4'h8}) ? c : 4'h0;
  endfunction

  function automatic logic f_probe(input int s, input svt_status_t st);
    case (s)
      0: return st.busy;
      1: return st.n_band;
      2: return st.r_band;
      4: return st.timeout_clk;
      5: return st.bias_min;
      6: return st.conv_busy;
      default: return 1'b0;
    endcase
  endfunction

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the several hundred cycles the tests need.
  initial begin
    #2000000;
    miscompares++;
    print_verdict;
  end

  initial begin
    seed = 1086;
    {NRST_I, WR_I, RD_I, PFD_TICK_I, TEST_MODE_I, CONV_VALID_I} = '0;
    {ADDR_I, WDATA_I, CONV_RESULT_I} = '0;
    STATUS_I = '0;
    repeat (5) @(posedge CLK_I);
    NRST_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    // Reset values, plus the start location and an unmapped one.
    for (int i = 0; i < NREG; i++) rd(REG_ADDR[i], REG_RST[i]);
    chk(PUMP_NORMAL_O, 1'b1);
    rd(ADDR_START, 8'h00);
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
    $display("test reset values done");
    // Random data: only writable bits stick.
    for (int i = 0; i < NREG; i++) begin
      d = 8'($random(seed));
      wr(REG_ADDR[i], d);
      rd(REG_ADDR[i], d & REG_WMASK[i]);
    end
    $display("test write masks done");
    // Start needs both enables; two writes in a row give two pulses.
    for (int k = 0; k < 4; k++) begin
      wr(A_CONV_CTRL, 8'(k << 2));
      wr(ADDR_START, 8'($random(seed)));
      #1;
      chk(CONV_START_O, k == 3);
      wr(ADDR_START, 8'h00);
      #1;
      chk(CONV_START_O, k == 3);
    end
    $display("test start done");
    // With a tick every cycle the clock stays high 2*div+1 cycles.
    // A divider of 0x18 gives a 98-cycle period, near 100 kHz from a 10 MHz tick.
    // The random divider goes last so the enable test below sees a fast clock.
    @(posedge CLK_I);
    PFD_TICK_I <= 1'b1;
    wr(A_CLK_CTRL, 8'h00);
    for (int k = 0; k < 4; k++) begin
      d = (k < 2) ? 8'(k) : (k == 2) ? 8'h18 : 8'(2 + $unsigned($random(seed)) % 4);
      wr(A_CLK_DIV, d);
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      chk(n, 2 * d + 1);
    end
    // The converter enable wins over the clock disable bit.
    for (int k = 0; k < 2; k++) begin
      wr(A_CONV_CTRL, 8'(k << 2));
      wr(A_CLK_CTRL, 8'h04);
      n = 0;
      repeat (40) begin
        step;
        n += CONV_CLK_O;
      end
      chk(n != 0, k == 1);
    end
    $display("test converter clock done");
    // Offset trim saturates at zero; equal and just-below corners first.
    t = 8'($random(seed));
    wr(A_CAL_OFS, t);
    for (int k = 0; k < 8; k++) begin
      r = (k == 0) ? t : (k == 1) ? t - 8'h01 : 8'($random(seed));
      @(posedge CLK_I);
      CONV_RESULT_I <= r;
      CONV_VALID_I <= 1'b1;
      @(posedge CLK_I);
      CONV_VALID_I <= 1'b0;
      #1;
      chk({CAL_VALID_O, CAL_RESULT_O}, {1'b1, (r > t) ? r - t : 8'h00});
    end
    $display("test offset done");
    // Every core pattern and tune code under test mode.
    @(posedge CLK_I);
    TEST_MODE_I <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      d = 8'($random(seed));
      wr(A_BAND, d);
      wr(A_CORE_BIAS, {4'(c), ~4'(c)});
      wr(A_MUX_TUNE, 8'(c));
      step;
      chk(OVERRIDE_O, {1'b1, d, f_core(4'(c)), ~4'(c), f_tune(4'(c))});
    end
    @(posedge CLK_I);
    TEST_MODE_I <= 1'b0;
    step;
    chk(OVERRIDE_O, 21'h0);
    $display("test overrides done");
    // Every probe selection against random status.
    for (int s = 0; s < 8; s++) begin
      @(posedge CLK_I);
      STATUS_I <= 6'($random(seed));
      wr(A_MUX_TUNE, 8'(s << P_PROBE_LSB));
      step;
      chk(PROBE_O, f_probe(s, STATUS_I));
    end
    $display("test probe done");
    // Every pump test code.
    for (int p = 0; p < 4; p++) begin
      wr(A_PUMP_TEST, 8'(p << P_PUMP_LSB));
      step;
      chk({PUMP_TRISTATE_O, PUMP_NORMAL_O}, {p == 0, p == 3});
    end
    $display("test pump done");
    print_verdict;
  end
endmodule
